// [dv/cae_regs_props.sv]
`timescale 1ns/1ps
module cae_regs_props
   import cae_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] calendar_value,
   input wire logic lock_on,
   input wire logic irq
);
   // ----------------------------------------
   // register side properties
   // ----------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence lock_wr;
      psel && penable && !pready && pwrite && paddr == ADDR_LOCK;
   endsequence
   sequence key_ok;
      pwdata[31:8] == LOCK_KEY;
   endsequence
   lock_load_a: assert property (
      lock_wr ##0 key_ok |=> lock_on == $past(pwdata[0]))
      else $error("lock bit not loaded by keyed write");
   lock_key_a: assert property (
      $changed(lock_on) |-> $past(psel && penable && pwrite &&
      paddr == ADDR_LOCK && pwdata[31:8] == LOCK_KEY))
      else $error("lock bit changed without key");
   irq_fall_a: assert property (
      $fell(irq) |-> $past(psel && penable && pwrite))
      else $error("irq dropped without a clearing write");
   cal_write_a: assert property (
      $changed(calendar_value) |->
      $past(psel && penable && pwrite && paddr == ADDR_CALENDAR))
      else $error("calendar changed without a write");
   cal_unused_a: assert property (
      (calendar_value & ~CALENDAR_MASK) == 32'h0)
      else $error("unused calendar bits set");
   hundreds_of_years_range_a: assert property (
      calendar_value[6:0] inside {7'h19, 7'h20})
      else $error("century out of range");
   year_bcd_a: assert property (
      calendar_value[15:12] <= 4'h9 && calendar_value[11:8] <= 4'h9)
      else $error("year not bcd");
   month_range_a: assert property (
      calendar_value[20:16] inside {[5'h01:5'h09], [5'h10:5'h12]})
      else $error("month out of range");
   dow_range_a: assert property (
      calendar_value[23:21] != 3'h0)
      else $error("day of week zero");
   dom_range_a: assert property (
      calendar_value[29:24] inside {[6'h01:6'h09], [6'h10:6'h19],
      [6'h20:6'h29], 6'h30, 6'h31})
      else $error("day of month out of range");
endmodule
bind cae_regs cae_regs_props cae_regs_props_i (.sys_clk(sys_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .calendar_value(calendar_value), .lock_on(lock_on), .irq(irq));

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import cae_pkg::*;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic update_granted, lock_on, irq, err;
   logic [31:0] paddr, pwdata, prdata, cal, ctl, rd;
   cae_events_t events;
   cae_now_t now;
   int mismatches, n_checks;
   cae_regs cae_regs_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .update_granted(update_granted), .events(events), .now(now),
      .calendar_value(cal), .control_value(ctl), .lock_on(lock_on),
      .irq(irq));
   // ----------------------------------------
   // bus and check helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // only the watchdog ends a stalled wait
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [31:0] a, exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // strobes last exactly one cycle, as the counters give them
   task automatic pulse(input cae_events_t e);
      @(posedge sys_clk);
      events <= e;
      @(posedge sys_clk);
      events <= '0;
      @(posedge sys_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdc(ADDR_FLAGS, 32'h0);
      rdc(ADDR_IRQ_MASK, 32'h0);
      rdc(ADDR_ALARM_DATE, RST_ALARM_DATE);
      rdc(ADDR_IRQ_SET, 32'h0);
      chk(cal, RST_CALENDAR);
      chk(ctl, RST_CONTROL);
      $display("test reset done");
   endtask
   task automatic t_flags;
      update_granted <= 1'b1;
      @(posedge sys_clk);
      update_granted <= 1'b0;
      rdc(ADDR_FLAGS, 32'h1);
      wr(ADDR_FLAG_CLEAR, 32'h1e);
      rdc(ADDR_FLAGS, 32'h1);
      wr(ADDR_FLAG_CLEAR, 32'h1);
      rdc(ADDR_FLAGS, 32'h0);
      pulse(7'h40);
      rdc(ADDR_FLAGS, 32'h4);
      wr(ADDR_IRQ_SET, 32'h1f);
      rdc(ADDR_IRQ_MASK, 32'h1f);
      chk(irq, 1'b1);
      wr(ADDR_IRQ_CLR, 32'h05);
      rdc(ADDR_IRQ_MASK, 32'h1a);
      chk(irq, 1'b0);
      wr(ADDR_IRQ_SET, 32'h0);
      rdc(ADDR_IRQ_MASK, 32'h1a);
      wr(ADDR_IRQ_CLR, 32'h1f);
      rdc(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_FLAG_CLEAR, 32'h4);
      $display("test flags done");
   endtask
   task automatic t_alarm;
      logic [31:0] at[8] = '{32'hb0, 32'hb0, 32'hc500, 32'hd10000,
         32'hd10000, 32'h0, 32'h0, 32'hb0};
      logic [31:0] ad[8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
         32'h890000, 32'h95000000, 32'h890000};
      logic [31:0] nv[8] = '{32'h60000041, 32'h62000041, 32'h01140041,
         32'h00011841, 32'h00011041, 32'h00000241, 32'h00000055,
         32'h60000041};
      logic [4:0] ex[8] = '{5'h6, 5'h4, 5'h6, 5'h6, 5'h4, 5'h6, 5'h6, 5'h4};
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_ALARM_TIME, at[i]);
         wr(ADDR_ALARM_DATE, ad[i]);
         now <= nv[i];
         pulse(7'h40);
         rdc(ADDR_FLAGS, {27'h0, ex[i]});
         wr(ADDR_FLAG_CLEAR, 32'h1f);
      end
      $display("test alarm done");
   endtask
   task automatic t_events;
      logic [6:0] tev[4] = '{7'h20, 7'h10, 7'h08, 7'h10};
      logic [6:0] cev[3] = '{7'h04, 7'h02, 7'h01};
      now <= 32'h00012041;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CONTROL, (32'(i) << TIME_SEL_LSB) |
            (32'(i % 3) << DATE_SEL_LSB));
         chk(ctl, (32'(i) << 8) | (32'(i % 3) << 16));
         pulse(tev[i] | cev[i % 3]);
         rdc(ADDR_FLAGS, 32'h18);
         wr(ADDR_FLAG_CLEAR, 32'h18);
      end
      wr(ADDR_CONTROL, 32'h0);
      pulse(7'h11);
      rdc(ADDR_FLAGS, 32'h0);
      $display("test events done");
   endtask
   task automatic t_lock;
      wr(ADDR_LOCK, 32'h52544401);
      chk(lock_on, 1'b0);
      wr(ADDR_LOCK, 32'h52544301);
      chk(lock_on, 1'b1);
      wr(ADDR_ALARM_TIME, 32'h1);
      rdc(ADDR_ALARM_TIME, 32'hb0);
      wr(ADDR_ALARM_DATE, 32'h0);
      rdc(ADDR_ALARM_DATE, 32'h890000);
      wr(ADDR_LOCK, 32'h52544300);
      wr(ADDR_ALARM_TIME, 32'h1);
      rdc(ADDR_ALARM_TIME, 32'h1);
      $display("test lock done");
   endtask
   task automatic t_cal;
      logic [31:0] bad[8] = '{32'h01210721, 32'h01210718, 32'h01219a20,
         32'h01330720, 32'h01200720, 32'h01010720, 32'h32210720,
         32'h00210720};
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CALENDAR, bad[i]);
         chk(err, 1'b1);
         chk(cal, RST_CALENDAR);
      end
      wr(ADDR_CALENDAR, 32'h31b29919);
      chk(err, 1'b0);
      chk(cal, 32'h31b29919);
      apb(1'b0, 32'h400e1a90, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("test calendar done");
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, psel, penable, pwrite, update_granted} = 5'h10;
      {paddr, pwdata} = '0;
      events = '0;
      now = 32'h00000041;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_flags;
      t_alarm;
      t_events;
      t_lock;
      t_cal;
      finish_test;
   end
   // whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      finish_test;
   end
endmodule

// [rtl/cae_regs.sv]
`timescale 1ns/1ps
// Functional notes
// - century field bcd, legal settings 19 to 20
// - year field bcd, legal settings 00 to 99
// - month field bcd, legal settings 01 to 12
// - day of week 1 to 7, no effect on day counting
// - day of month bcd, legal settings 01 to 31
// - bcd fields: units in low nibble, tens above
// - unused calendar register bits read zero
// - alarm register writes ignored while lock is on
// - second/minute alarm values, enables at bits 7 and 15
// - hour alarm with meridiem bit 22, enable bit 23
// - month alarm enable 23, day-of-month enable 31
// - alarm flag bit 1 sets on match, sticky until cleared
// - status bit 0 shows update granted
// - status bit 2 sticky on second tick
// - status bit 3 sticky on selected time event
// - status bit 4 sticky on selected calendar event
// - flag clear register: write one clears flag
// - irq enable register: write one sets mask bit
// - irq disable register: write one clears mask bit
// - mask register reads current mask bits
// - lock bit changes only with the correct key
module cae_regs
   import cae_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic update_granted,
   input wire cae_events_t events,
   input wire cae_now_t now,
   output logic [31:0] calendar_value,
   output logic [31:0] control_value,
   output logic lock_on,
   output logic irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be,
      input logic [31:0] keep);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge_bytes = r & keep;
   endfunction

   // checks a two digit bcd value against a range
   function automatic logic bcd_ok(input logic [7:0] v,
      input logic [7:0] lo, input logic [7:0] hi);
      bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) &&
         (v >= lo) && (v <= hi);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cae_state_t st;
   cae_state_t next_st;

   logic access;
   logic wr;
   logic rd;
   logic alarm_hit;
   logic time_ev;
   logic date_ev;
   logic cal_ok;
   logic [NUM_FLAGS-1:0] raise;
   logic [NUM_FLAGS-1:0] wipe;
   logic [31:0] wmask;
   logic [31:0] cal_wr;

   // ------------------------------------------------------------
   // event and match logic
   // ------------------------------------------------------------
   always_comb begin
      // disabled fields never block a match
      alarm_hit = (!st.alarm_time[SEC_EN_BIT] ||
            st.alarm_time[6:0] == now.sec) &&
         (!st.alarm_time[MIN_EN_BIT] ||
            st.alarm_time[14:8] == now.min) &&
         (!st.alarm_time[HOUR_EN_BIT] ||
            (st.alarm_time[21:16] == now.hour &&
             st.alarm_time[MERIDIEM_BIT] == now.meridiem_flag)) &&
         (!st.alarm_date[MONTH_EN_BIT] ||
            st.alarm_date[20:16] == now.month) &&
         (!st.alarm_date[DOM_EN_BIT] ||
            st.alarm_date[29:24] == now.dom);
      // an all-disabled alarm would fire forever; require one enable
      alarm_hit = alarm_hit && events.tick &&
         (st.alarm_time[SEC_EN_BIT] || st.alarm_time[MIN_EN_BIT] ||
          st.alarm_time[HOUR_EN_BIT] || st.alarm_date[MONTH_EN_BIT] ||
          st.alarm_date[DOM_EN_BIT]);
      unique case (cae_time_ev_t'(st.control[TIME_SEL_LSB +: 2]))
         TEV_MINUTE: time_ev = events.minute_change;
         TEV_HOUR: time_ev = events.hour_change;
         TEV_MIDNIGHT: time_ev = events.day_change;
         TEV_NOON: time_ev = events.hour_change &&
            {2'h0, now.hour} == BCD_NOON;
      endcase
      unique case (cae_date_ev_t'(st.control[DATE_SEL_LSB +: 2]))
         CEV_WEEK: date_ev = events.week_change;
         CEV_MONTH: date_ev = events.month_change;
         CEV_YEAR: date_ev = events.year_change;
         CEV_NONE: date_ev = 1'b0;
      endcase
      raise = '0;
      raise[FLAG_GRANT] = update_granted;
      raise[FLAG_ALARM] = alarm_hit;
      raise[FLAG_TICK] = events.tick;
      raise[FLAG_TIME] = time_ev;
      raise[FLAG_DATE] = date_ev;
   end

   // ------------------------------------------------------------
   // bus and register update
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      access = psel && penable && !st.pready;
      wr = access && pwrite;
      rd = access && !pwrite;
      wipe = '0;
      next_st.pready = access;
      next_st.pslverr = 1'b0;
      next_st.prdata = '0;
      cal_wr = merge_bytes(st.calendar, pwdata, pstrb, CALENDAR_MASK);
      // reject out of range calendar values, keep the old one
      cal_ok = bcd_ok(cal_wr[7:0], 8'h19, 8'h20) &&
         bcd_ok(cal_wr[15:8], 8'h00, 8'h99) &&
         bcd_ok({3'h0, cal_wr[20:16]}, 8'h01, 8'h12) &&
         cal_wr[23:21] >= 3'h1 && cal_wr[23:21] <= 3'h7 &&
         bcd_ok({2'h0, cal_wr[29:24]}, 8'h01, 8'h31);
      wmask = pwdata & {{(32-NUM_FLAGS){1'b0}}, {NUM_FLAGS{1'b1}}};
      if (wr) begin
         unique case (paddr)
            ADDR_ALARM_TIME: begin
               if (!st.lock_on) begin
                  next_st.alarm_time = merge_bytes(st.alarm_time, pwdata,
                     pstrb, ALARM_TIME_MASK);
               end
            end
            ADDR_ALARM_DATE: begin
               if (!st.lock_on) begin
                  next_st.alarm_date = merge_bytes(st.alarm_date, pwdata,
                     pstrb, ALARM_DATE_MASK);
               end
            end
            ADDR_CALENDAR: begin
               if (cal_ok) begin
                  next_st.calendar = cal_wr;
               end else begin
                  next_st.pslverr = 1'b1;
               end
            end
            ADDR_CONTROL: begin
               if (!st.lock_on) begin
                  next_st.control = merge_bytes(st.control, pwdata,
                     pstrb, CONTROL_MASK);
               end
            end
            ADDR_LOCK: begin
               if (pwdata[31:8] == LOCK_KEY) begin
                  next_st.lock_on = pwdata[LOCK_BIT];
               end
            end
            ADDR_FLAG_CLEAR: wipe = wmask[NUM_FLAGS-1:0];
            ADDR_IRQ_SET: begin
               next_st.mask = st.mask | wmask[NUM_FLAGS-1:0];
            end
            ADDR_IRQ_CLR: begin
               next_st.mask = st.mask & ~wmask[NUM_FLAGS-1:0];
            end
            ADDR_FLAGS, ADDR_IRQ_MASK: next_st.pslverr = 1'b0;
            default: next_st.pslverr = 1'b1;
         endcase
      end
      if (rd) begin
         unique case (paddr)
            ADDR_ALARM_TIME: next_st.prdata = st.alarm_time;
            ADDR_ALARM_DATE: next_st.prdata = st.alarm_date;
            ADDR_CALENDAR: next_st.prdata = st.calendar;
            ADDR_CONTROL: next_st.prdata = st.control;
            ADDR_LOCK: next_st.prdata = {31'h0, st.lock_on};
            ADDR_FLAGS: next_st.prdata = {27'h0, st.flags};
            ADDR_IRQ_MASK: next_st.prdata = {27'h0, st.mask};
            ADDR_FLAG_CLEAR, ADDR_IRQ_SET, ADDR_IRQ_CLR:
               next_st.prdata = '0;
            default: next_st.pslverr = 1'b1;
         endcase
      end
      // a new event in the clearing cycle wins over the clear
      next_st.flags = (st.flags & ~wipe) | raise;
      next_st.irq = |(next_st.flags & next_st.mask);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '{alarm_time: RST_ALARM_TIME, alarm_date: RST_ALARM_DATE,
            calendar: RST_CALENDAR, control: RST_CONTROL,
            default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign calendar_value = st.calendar;
   assign control_value = st.control;
   assign lock_on = st.lock_on;
   assign irq = st.irq;

endmodule

// [shared/cae_pkg.sv]
package cae_pkg;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_ALARM_TIME = 32'h400e1a70;
   localparam logic [31:0] ADDR_ALARM_DATE = 32'h400e1a74;
   localparam logic [31:0] ADDR_FLAGS = 32'h400e1a78;
   localparam logic [31:0] ADDR_FLAG_CLEAR = 32'h400e1a7c;
   localparam logic [31:0] ADDR_IRQ_SET = 32'h400e1a80;
   localparam logic [31:0] ADDR_IRQ_CLR = 32'h400e1a84;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h400e1a88;
   localparam logic [31:0] ADDR_CALENDAR = 32'h400e1a6c;
   localparam logic [31:0] ADDR_CONTROL = 32'h400e1a60;
   localparam logic [31:0] ADDR_LOCK = 32'h400e1b44;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SEC_EN_BIT = 7;
   localparam int MIN_EN_BIT = 15;
   localparam int MERIDIEM_BIT = 22;
   localparam int HOUR_EN_BIT = 23;
   localparam int MONTH_EN_BIT = 23;
   localparam int DOM_EN_BIT = 31;
   localparam int FLAG_GRANT = 0;
   localparam int FLAG_ALARM = 1;
   localparam int FLAG_TICK = 2;
   localparam int FLAG_TIME = 3;
   localparam int FLAG_DATE = 4;
   localparam int NUM_FLAGS = 5;
   localparam int TIME_SEL_LSB = 8;
   localparam int DATE_SEL_LSB = 16;
   localparam int LOCK_BIT = 0;

   // ------------------------------------------------------------
   // masks, keys and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ALARM_TIME_MASK = 32'h00ffffff;
   localparam logic [31:0] ALARM_DATE_MASK = 32'hbf9f0000;
   localparam logic [31:0] CALENDAR_MASK = 32'h3fffff7f;
   localparam logic [31:0] CONTROL_MASK = 32'h00030300;
   localparam logic [23:0] LOCK_KEY = 24'h525443;
   localparam logic [31:0] RST_ALARM_TIME = 32'h00000000;
   localparam logic [31:0] RST_ALARM_DATE = 32'h01010000;
   localparam logic [31:0] RST_CALENDAR = 32'h01210720;
   localparam logic [31:0] RST_CONTROL = 32'h00000000;
   localparam logic [7:0] BCD_NOON = 8'h12;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TEV_MINUTE = 2'h0,
      TEV_HOUR = 2'h1,
      TEV_MIDNIGHT = 2'h2,
      TEV_NOON = 2'h3
   } cae_time_ev_t;

   typedef enum logic [1:0] {
      CEV_WEEK = 2'h0,
      CEV_MONTH = 2'h1,
      CEV_YEAR = 2'h2,
      CEV_NONE = 2'h3
   } cae_date_ev_t;

   // one-cycle change strobes from the counter logic
   typedef struct packed {
      logic tick;
      logic minute_change;
      logic hour_change;
      logic day_change;
      logic week_change;
      logic month_change;
      logic year_change;
   } cae_events_t;

   // current counter values, bcd
   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] hour;
      logic meridiem_flag;
      logic [4:0] month;
      logic [5:0] dom;
   } cae_now_t;

   typedef struct packed {
      logic [31:0] alarm_time;
      logic [31:0] alarm_date;
      logic [31:0] calendar;
      logic [31:0] control;
      logic lock_on;
      logic [NUM_FLAGS-1:0] flags;
      logic [NUM_FLAGS-1:0] mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cae_state_t;

endpackage
